// File: rtl/fsil_regs.vh
// Functional notes
// - Status one, status two and receive info bits latch high on their event or alarm.
// - A latched bit holds until read; the read clears it until the event recurs.
// - Condition alarm bits stay set after a read while the alarm persists.
// - Mask write ones refresh the readable copy from the latest latched state.
// - Mask write zeros leave the readable copy holding its previous value.
// - Sync state register is read only, live, and needs no mask write.
// - Each status one and status two bit can drive the interrupt, gated by its mask bit; link controller requests are not masked.
// - Four line alarms raise the interrupt on every change of state, both directions.
// - A state change interrupt drops once its alarm bit is read, if nothing else pends.
// - Event sources raise the interrupt when the event occurs.
// - An event interrupt drops once its event bit is read, if nothing else pends.
// - Interrupt summary answers identically at every address 0C0 to 0FF.
// - Framer n status request sits at summary bit 2n, link controller at 2n+1.
// - A summary bit reads one while its source has a request pending, else zero.
`ifndef FSIL_REGS_VH
`define FSIL_REGS_VH

// ----------------------------------------
// Per framer register offsets
// ----------------------------------------
`define FSIL_ADDR_STAT_ONE    8'h06
`define FSIL_ADDR_STAT_TWO    8'h07
`define FSIL_ADDR_RX_INFO     8'h08
`define FSIL_ADDR_MASK_ONE    8'h16
`define FSIL_ADDR_MASK_TWO    8'h17
`define FSIL_ADDR_CTRL_SIX    8'h1D
`define FSIL_ADDR_SYNC_STATE  8'h1E
`define FSIL_ADDR_SUM_LO      8'hC0
`define FSIL_ADDR_SUM_HI      8'hFF

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FSIL_CTRL_SIX_TXCLK   2
`define FSIL_CTRL_SIX_RXES    1
`define FSIL_CTRL_SIX_TXES    0
`define FSIL_CTRL_SIX_MASK    8'h07
`define FSIL_STAT_ONE_CHG     8'h0F
`define FSIL_RST_BYTE         8'h00

`endif

// File: rtl/fsil_stat_reg.v
`include "fsil_regs.vh"

// ----------------------------------------
// One latched status byte with read copy
// ----------------------------------------
module fsil_stat_reg #(
    parameter [7:0] CHG_BITS = 8'h00
) (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rstn,
    // Sources: event pulses or alarm levels
    input  wire [7:0] i_src,
    // Host access
    input  wire       i_wr,
    input  wire [7:0] i_wdata,
    input  wire       i_rd,
    input  wire [7:0] i_irq_mask,
    // Results
    output reg  [7:0] o_rdata,
    output wire       o_irq
);

    reg  [7:0] latch_q;
    reg  [7:0] latch_d;
    reg  [7:0] prev_q;
    reg  [7:0] chg_q;
    reg  [7:0] chg_d;
    reg  [7:0] view_d;
    wire [7:0] clr;

    // A read clears only the bits the host actually saw
    assign clr = i_rd ? o_rdata : `FSIL_RST_BYTE;

    // Next state; a set in the clear cycle wins
    always @* begin
        // Level sources re-set at once, so alarms persist past reads
        latch_d = i_src | (latch_q & ~clr);
        chg_d   = (CHG_BITS & (i_src ^ prev_q)) | (chg_q & ~clr);
        view_d  = (o_rdata & ~i_wdata) | ((latch_q | i_src) & i_wdata);
        if (!i_wr) begin
            view_d = o_rdata;
        end
    end

    // State registers
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            latch_q <= `FSIL_RST_BYTE;
            prev_q  <= `FSIL_RST_BYTE;
            chg_q   <= `FSIL_RST_BYTE;
            o_rdata <= `FSIL_RST_BYTE;
        end else begin
            latch_q <= latch_d;
            prev_q  <= i_src;
            chg_q   <= chg_d;
            o_rdata <= view_d;
        end
    end

    // Change bits request on toggles, others on the latch itself
    assign o_irq = |((((latch_q & ~CHG_BITS) | chg_q)) & i_irq_mask);

endmodule

// File: rtl/fsil_top.v
`include "fsil_regs.vh"

// ----------------------------------------
// Quad framer status and interrupt logic
// ----------------------------------------
module fsil_top #(
    parameter NFR = 4
) (
    // Clock and reset
    input  wire             i_clk_sys,
    input  wire             i_rstn,
    // Control port, synchronous strobes
    input  wire [1:0]       i_fsel,
    input  wire [7:0]       i_addr,
    input  wire [7:0]       i_wdata,
    input  wire             i_wr_en,
    input  wire             i_rd_en,
    output reg  [7:0]       o_rdata,
    output reg              o_rvalid,
    // Framer sources, byte n belongs to framer n
    input  wire [8*NFR-1:0] i_stat_one_src,
    input  wire [8*NFR-1:0] i_stat_two_src,
    input  wire [8*NFR-1:0] i_rx_info_src,
    input  wire [8*NFR-1:0] i_sync_state,
    input  wire [NFR-1:0]   i_link_ctrl_req,
    // Framer controls
    output wire [NFR-1:0]   o_tx_clock_source_select,
    output reg  [NFR-1:0]   o_rx_elastic_reset,
    output reg  [NFR-1:0]   o_tx_elastic_reset,
    // Interrupt
    output reg              o_int_n,
    output wire [7:0]       o_interrupt_summary
);

    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------

    // Summary answers over a whole block of addresses
    function is_summary;
        input [7:0] a;
        begin
            is_summary = (a >= `FSIL_ADDR_SUM_LO) && (a <= `FSIL_ADDR_SUM_HI);
        end
    endfunction

    // Strobe for one framer register
    function hit;
        input         en;
        input   [1:0] sel;
        input integer fr;
        input   [7:0] a;
        input   [7:0] reg_addr;
        begin
            hit = en && ({30'h0, sel} == fr) && (a == reg_addr) && !is_summary(a);
        end
    endfunction

    // ----------------------------------------
    // Per framer storage
    // ----------------------------------------
    reg  [7:0]       mask_one_q [0:NFR-1];
    reg  [7:0]       mask_two_q [0:NFR-1];
    reg  [7:0]       ctrl_six_q [0:NFR-1];
    wire [8*NFR-1:0] stat_one_view;
    wire [8*NFR-1:0] stat_two_view;
    wire [8*NFR-1:0] rx_info_view;
    wire [NFR-1:0]   stat_one_irq;
    wire [NFR-1:0]   stat_two_irq;
    wire [2*NFR-1:0] summary;

    genvar g;
    generate
        for (g = 0; g < NFR; g = g + 1) begin : fr
            // Four line alarms raise only on change of state, not on their latch
            fsil_stat_reg #(
                .CHG_BITS (`FSIL_STAT_ONE_CHG)
            ) u_stat_one (
                .i_clk_sys  (i_clk_sys),
                .i_rstn     (i_rstn),
                .i_src      (i_stat_one_src[8*g+7:8*g]),
                .i_wr       (hit(i_wr_en, i_fsel, g, i_addr, `FSIL_ADDR_STAT_ONE)),
                .i_wdata    (i_wdata),
                .i_rd       (hit(i_rd_en, i_fsel, g, i_addr, `FSIL_ADDR_STAT_ONE)),
                .i_irq_mask (mask_one_q[g]),
                .o_rdata    (stat_one_view[8*g+7:8*g]),
                .o_irq      (stat_one_irq[g])
            );

            // Status two holds only event bits
            fsil_stat_reg #(
                .CHG_BITS (8'h00)
            ) u_stat_two (
                .i_clk_sys  (i_clk_sys),
                .i_rstn     (i_rstn),
                .i_src      (i_stat_two_src[8*g+7:8*g]),
                .i_wr       (hit(i_wr_en, i_fsel, g, i_addr, `FSIL_ADDR_STAT_TWO)),
                .i_wdata    (i_wdata),
                .i_rd       (hit(i_rd_en, i_fsel, g, i_addr, `FSIL_ADDR_STAT_TWO)),
                .i_irq_mask (mask_two_q[g]),
                .o_rdata    (stat_two_view[8*g+7:8*g]),
                .o_irq      (stat_two_irq[g])
            );

            // Receive info latches but has no interrupt path
            fsil_stat_reg #(
                .CHG_BITS (8'h00)
            ) u_rx_info (
                .i_clk_sys  (i_clk_sys),
                .i_rstn     (i_rstn),
                .i_src      (i_rx_info_src[8*g+7:8*g]),
                .i_wr       (hit(i_wr_en, i_fsel, g, i_addr, `FSIL_ADDR_RX_INFO)),
                .i_wdata    (i_wdata),
                .i_rd       (hit(i_rd_en, i_fsel, g, i_addr, `FSIL_ADDR_RX_INFO)),
                .i_irq_mask (`FSIL_RST_BYTE),
                .o_rdata    (rx_info_view[8*g+7:8*g]),
                .o_irq      ()
            );

            // Status pair at even bit, link controller at odd bit
            assign summary[2*g]   = stat_one_irq[g] | stat_two_irq[g];
            assign summary[2*g+1] = i_link_ctrl_req[g];

            // Clock source select is a plain level to the formatter
            assign o_tx_clock_source_select[g] = ctrl_six_q[g][`FSIL_CTRL_SIX_TXCLK];
        end
    endgenerate

    // Summary is live: one exactly while a source pends
    assign o_interrupt_summary = summary;

    // ----------------------------------------
    // Mask and control registers
    // ----------------------------------------

    // Software writes; unassigned control bits stay zero
    integer i;
    integer j;
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            for (i = 0; i < NFR; i = i + 1) begin
                mask_one_q[i] <= `FSIL_RST_BYTE;
                mask_two_q[i] <= `FSIL_RST_BYTE;
                ctrl_six_q[i] <= `FSIL_RST_BYTE;
            end
        end else begin
            for (i = 0; i < NFR; i = i + 1) begin
                if (hit(i_wr_en, i_fsel, i, i_addr, `FSIL_ADDR_MASK_ONE)) begin
                    mask_one_q[i] <= i_wdata;
                end
                if (hit(i_wr_en, i_fsel, i, i_addr, `FSIL_ADDR_MASK_TWO)) begin
                    mask_two_q[i] <= i_wdata;
                end
                if (hit(i_wr_en, i_fsel, i, i_addr, `FSIL_ADDR_CTRL_SIX)) begin
                    ctrl_six_q[i] <= i_wdata & `FSIL_CTRL_SIX_MASK;
                end
            end
        end
    end

    // ----------------------------------------
    // Elastic store reset pulses
    // ----------------------------------------

    // Only a zero to one step resets; the bit must be cleared to rearm
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rx_elastic_reset <= {NFR{1'b0}};
            o_tx_elastic_reset <= {NFR{1'b0}};
        end else begin
            for (j = 0; j < NFR; j = j + 1) begin
                o_rx_elastic_reset[j] <= hit(i_wr_en, i_fsel, j, i_addr, `FSIL_ADDR_CTRL_SIX)
                                         && i_wdata[`FSIL_CTRL_SIX_RXES]
                                         && !ctrl_six_q[j][`FSIL_CTRL_SIX_RXES];
                o_tx_elastic_reset[j] <= hit(i_wr_en, i_fsel, j, i_addr, `FSIL_ADDR_CTRL_SIX)
                                         && i_wdata[`FSIL_CTRL_SIX_TXES]
                                         && !ctrl_six_q[j][`FSIL_CTRL_SIX_TXES];
            end
        end
    end

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    reg [7:0] rd_mux;

    // Unmapped reads return zero rather than floating
    always @* begin
        rd_mux = `FSIL_RST_BYTE;
        if (is_summary(i_addr)) begin
            rd_mux = summary;
        end else begin
            case (i_addr)
                `FSIL_ADDR_STAT_ONE:   rd_mux = stat_one_view[8*i_fsel +: 8];
                `FSIL_ADDR_STAT_TWO:   rd_mux = stat_two_view[8*i_fsel +: 8];
                `FSIL_ADDR_RX_INFO:    rd_mux = rx_info_view[8*i_fsel +: 8];
                `FSIL_ADDR_MASK_ONE:   rd_mux = mask_one_q[i_fsel];
                `FSIL_ADDR_MASK_TWO:   rd_mux = mask_two_q[i_fsel];
                `FSIL_ADDR_CTRL_SIX:   rd_mux = ctrl_six_q[i_fsel];
                `FSIL_ADDR_SYNC_STATE: rd_mux = i_sync_state[8*i_fsel +: 8];
                default:               rd_mux = `FSIL_RST_BYTE;
            endcase
        end
    end

    // Read data registered; host mask-read-writeback relies on this copy
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rdata  <= `FSIL_RST_BYTE;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------

    // Registered to keep the pin glitch free
    always @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= ~|summary;
        end
    end

endmodule

// File: tb/fsil_host.sv
// ----------------------------------------
// Host processor on the control port
// ----------------------------------------
module fsil_host (
    // Clock and answer
    input  wire       i_clk_sys,
    input  wire [7:0] i_rdata,
    // Strobes and address
    output reg  [1:0] o_fsel,
    output reg  [7:0] o_addr,
    output reg  [7:0] o_wdata,
    output reg        o_wr_en,
    output reg        o_rd_en
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bus idle from time zero
    initial begin
        o_fsel  = 2'h0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
    end
    // Single write; released lines show inverted values, not stale ones
    task wr(input [1:0] f, input [7:0] a, input [7:0] d);
        @(posedge i_clk_sys);
        #1;
        {o_fsel, o_addr, o_wdata, o_wr_en} = {f, a, d, 1'b1};
        @(posedge i_clk_sys);
        #1;
        {o_addr, o_wdata, o_wr_en} = {~a, ~d, 1'b0};
    endtask
    // Single read, data taken when the answer is valid
    task rd(input [1:0] f, input [7:0] a, output [7:0] d);
        @(posedge i_clk_sys);
        #1;
        {o_fsel, o_addr, o_rd_en} = {f, a, 1'b1};
        @(posedge i_clk_sys);
        #1;
        {o_addr, o_rd_en} = {~a, 1'b0};
        @(posedge i_clk_sys);
        d = i_rdata;
        #1;
    endtask
    // Write mask, read at once, write back the ANDed value
    task poll(input [1:0] f, input [7:0] a, input [7:0] m, output [7:0] d);
        wr(f, a, m);
        rd(f, a, d);
        wr(f, a, d & m);
    endtask
endmodule

// File: tb/fsil_top_sva.sv
// ----------------------------------------
// Port checker for the status interrupt top
// ----------------------------------------
module fsil_top_sva #(
    parameter NFR = 4
) (
    // Clock, reset and control port
    input wire             i_clk_sys,
    input wire             i_rstn,
    input wire [1:0]       i_fsel,
    input wire [7:0]       i_addr,
    input wire [7:0]       i_wdata,
    input wire             i_wr_en,
    input wire             i_rd_en,
    input wire [7:0]       o_rdata,
    input wire             o_rvalid,
    // Framer side and interrupt
    input wire [8*NFR-1:0] i_sync_state,
    input wire [NFR-1:0]   o_tx_clock_source_select,
    input wire [NFR-1:0]   o_rx_elastic_reset,
    input wire             o_int_n,
    input wire [7:0]       o_interrupt_summary
);
    timeunit 1ns;
    timeprecision 100ps;
    // One clock domain, reset gates every check
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    read_answer_a:
        assert property (i_rd_en |=> o_rvalid) else $error("read not answered");
    answer_hold_a:
        assert property (!i_rd_en |=> !o_rvalid && $stable(o_rdata)) else $error("answer without read");
    summary_read_a:
        assert property (i_rd_en && i_addr >= 8'hC0 |=> o_rdata == $past(o_interrupt_summary))
            else $error("summary read mismatch");
    int_drive_a:
        assert property (o_interrupt_summary != 8'h00 |=> !o_int_n) else $error("interrupt not driven");
    int_release_a:
        assert property (o_interrupt_summary == 8'h00 |=> o_int_n) else $error("interrupt not released");
    sync_live_a:
        assert property (i_rd_en && i_addr == 8'h1E |=> o_rdata == $past(i_sync_state[8*i_fsel+:8]))
            else $error("sync state not live");
    clock_select_a:
        assert property (i_wr_en && i_addr == 8'h1D
            |=> o_tx_clock_source_select[$past(i_fsel)] == $past(i_wdata[2])) else $error("clock select");
    reset_pulse_a:
        assert property (o_rx_elastic_reset != 0 |=> o_rx_elastic_reset == 0) else $error("reset not a pulse");
    // Main scenarios reached
    cover property (i_rd_en && i_addr >= 8'hC0 && o_interrupt_summary != 8'h00);
    cover property ($fell(o_int_n));
    cover property (o_rx_elastic_reset != 0);
endmodule

bind fsil_top fsil_top_sva #(.NFR(NFR)) u_sva (.*);

// File: tb/fsil_top_test.sv
// ----------------------------------------
// Testbench for the status interrupt logic
// ----------------------------------------
module fsil_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rstn;
    wire  [1:0]  fsel;
    wire  [7:0]  addr, wdata, rdata, summ;
    wire         wr_en, rd_en, rvalid, int_n;
    wire  [3:0]  clk_sel, rx_rst, tx_rst;
    logic [31:0] stat1_src, stat2_src, info_src, sync_st;
    logic [3:0]  link_req, st_pend;
    logic [7:0]  v, rst_seen;
    integer      seed, err_total, checks_done, fr, b, i;

    fsil_host host (.i_clk_sys(clk), .i_rdata(rdata), .o_fsel(fsel), .o_addr(addr),
        .o_wdata(wdata), .o_wr_en(wr_en), .o_rd_en(rd_en));
    fsil_top #(.NFR(4)) dut (.i_clk_sys(clk), .i_rstn(rstn), .i_fsel(fsel), .i_addr(addr),
        .i_wdata(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_stat_one_src(stat1_src), .i_stat_two_src(stat2_src), .i_rx_info_src(info_src), .i_sync_state(sync_st),
        .i_link_ctrl_req(link_req), .o_tx_clock_source_select(clk_sel), .o_rx_elastic_reset(rx_rst),
        .o_tx_elastic_reset(tx_rst), .o_int_n(int_n), .o_interrupt_summary(summ));

    // Clock, watchdog and elastic reset pulse collector
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        err_total = err_total + 1;
        end_sim;
    end
    always @(posedge clk) rst_seen = rst_seen | {tx_rst, rx_rst};

    // Compare, summary model, wait, verdict
    task chk(input [7:0] got, input [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function [7:0] exp_sum;
        integer n;
        for (n = 0; n < 4; n++) exp_sum[2*n+:2] = {link_req[n], st_pend[n]};
    endfunction
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        {seed, err_total, checks_done, rstn} = {32'hCDB0, 32'h0, 32'h0, 1'b0};
        {stat1_src, stat2_src, info_src, sync_st, link_req, st_pend, rst_seen} = 0;
        tick(5);
        rstn = 1'b1;
        tick(1);
        chk({7'h0, int_n}, 8'h01);
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            link_req = v[3:0];
            host.rd(v[5:4], 8'hC0 | {2'h0, v[7:2]}, v);
            chk(v, exp_sum());
            tick(2);
            chk({7'h0, int_n}, {7'h0, link_req == 4'h0});
        end
        link_req = 4'h0;
        host.rd(2'h0, 8'h40, v);
        chk(v, 8'h00);
        // Event bit per framer: latch, masked write of zeros, poll, release
        for (fr = 0; fr < 4; fr++) begin
            b = $random(seed) & 7;
            host.wr(fr, 8'h17, 8'h01 << b);
            stat2_src[fr*8+b] = 1'b1;
            tick(1);
            stat2_src = 32'h0;
            tick(2);
            st_pend = 4'h1 << fr;
            chk(summ, exp_sum());
            chk({7'h0, int_n}, 8'h00);
            host.wr(fr, 8'h07, 8'h00);
            host.rd(fr, 8'h07, v);
            chk(v, 8'h00);
            host.poll(fr, 8'h07, 8'hFF, v);
            chk(v, 8'h01 << b);
            st_pend = 4'h0;
            tick(2);
            chk(summ, exp_sum());
            chk({7'h0, int_n}, 8'h01);
            host.poll(fr, 8'h07, 8'hFF, v);
            chk(v, 8'h00);
        end
        // Line alarm level: both edges interrupt, bit persists while present
        fr = $random(seed) & 3;
        b = $random(seed) & 3;
        host.wr(fr, 8'h16, 8'h0F);
        stat1_src[fr*8+b] = 1'b1;
        tick(3);
        chk({7'h0, int_n}, 8'h00);
        for (i = 0; i < 4; i++) begin
            if (i == 2) begin
                stat1_src = 32'h0;
                tick(3);
                chk({7'h0, int_n}, 8'h00);
            end
            host.poll(fr, 8'h06, 8'h0F, v);
            chk(v, (i < 3) ? (8'h01 << b) : 8'h00);
            tick(2);
            chk({7'h0, int_n}, 8'h01);
        end
        // Receive info latches without interrupt; mask one reads back
        host.rd(fr, 8'h16, v);
        chk(v, 8'h0F);
        info_src[fr*8+b] = 1'b1;
        tick(1);
        info_src = 32'h0;
        tick(2);
        chk({7'h0, int_n}, 8'h01);
        host.poll(fr, 8'h08, 8'hFF, v);
        chk(v, 8'h01 << b);
        host.poll(fr, 8'h08, 8'hFF, v);
        chk(v, 8'h00);
        // Live sync state and control six with reset pulses
        sync_st = $random(seed);
        host.rd(fr, 8'h1E, v);
        chk(v, sync_st[fr*8+:8]);
        rst_seen = 8'h00;
        host.wr(fr, 8'h1D, 8'h07);
        tick(3);
        chk(rst_seen, {2{4'h1 << fr}});
        chk({4'h0, clk_sel}, 8'h01 << fr);
        rst_seen = 8'h00;
        host.wr(fr, 8'h1D, 8'h07);
        tick(3);
        chk(rst_seen, 8'h00);
        host.rd(fr, 8'h1D, v);
        chk(v, 8'h07);
        host.wr(fr, 8'h1D, 8'h00);
        tick(1);
        chk({4'h0, clk_sel}, 8'h00);
        end_sim;
    end
endmodule
